/* fcs_pkg.sv */
// package: flash command codes, status layout, host register map, timing
package fcs_pkg;
  // device command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  // engine_state_flags bit positions
  localparam int READY_BIT = 7;
  localparam int SUSPEND_BIT = 6;
  localparam int ERASE_ERROR_BIT = 5;
  localparam int WRITE_ERROR_BIT = 4;
  localparam int SUPPLY_ERROR_BIT = 3;
  // host registers, byte offsets on AXI4-Lite
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  // host operations written into CTRL[2:0]
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_CMD = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_ERASE = 3'h3;
  localparam logic [2:0] OP_POLL = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
  // bus strobe and reset pulse timing; AXI response codes
  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 60;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_NS = 100;
  localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pin group driven to the flash
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rp_n;
    logic [17:0] addr;
  } fcs_pins_s;
endpackage : fcs_pkg

/* fcs_strobe.sv */
// single flash bus cycle generator: write or read strobe of fixed width
module fcs_strobe #(
  parameter int WIDTH = fcs_pkg::STROBE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic is_write_i,
  input wire logic [7:0] dq_in_i,
  output logic busy_o,
  output logic done_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic ce_n_o,
  output logic dq_oe_o,
  output logic [7:0] rdata_o
);
  logic [7:0] cnt;
  logic wr;
  // counts the strobe low time; command latches on we_n rising edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      ce_n_o <= 1'b1;
      dq_oe_o <= 1'b0;
      wr <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        wr <= is_write_i;
        cnt <= 8'(WIDTH);
        ce_n_o <= 1'b0;
        we_n_o <= !is_write_i; // oe high during writes
        oe_n_o <= is_write_i;
        dq_oe_o <= is_write_i;
      end else if (busy_o) begin
        if (cnt == 8'h01) begin
          if (!wr) begin
            rdata_o <= dq_in_i;
          end
          we_n_o <= 1'b1; // rising edge captures code
          oe_n_o <= 1'b1; // toggling oe refreshes status
          ce_n_o <= 1'b1;
          cnt <= 8'h00;
        end else if (cnt == 8'h00) begin
          dq_oe_o <= 1'b0; // hold data one cycle past the edge
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule : fcs_strobe

/* fcs_host.sv */
// flash host controller: AXI4-Lite registers to flash command sequences
// What this block does
// - only defined command codes are sent, save a 00 write for CTRL ops 6 and 7; other command codes get a bus error
// - no array read command sent before array reads; the flash is read in whatever mode it is in
// - ready bit polled until set before trusting result flags
// - array mode not restored after program or erase; program setup precedes every write
// - command cycle: oe high, ce and we low, latch on we rise
module fcs_host (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output fcs_pkg::fcs_pins_s FL_PINS_O,
  output logic [7:0] FL_DQ_O,
  output logic FL_DQ_OE_O,
  input wire logic [7:0] FL_DQ_I
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_CYC = 4'b0001, ST_WAIT = 4'b0010,
    ST_POLL = 4'b0011, ST_RST = 4'b0100, ST_DONE = 4'b0101
  } fcs_state_e;
  fcs_state_e state;
  logic [2:0] op;
  logic [1:0] step;
  logic [17:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] status;
  logic busy;
  logic refused;
  logic suspended;
  logic array_mode;
  logic [7:0] rst_cnt;
  logic aw_got, w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic cyc_start, cyc_write, cyc_busy, cyc_done;
  logic [7:0] cyc_dq, cyc_rdata;
  logic s_we_n, s_oe_n, s_ce_n, s_dq_oe;
  // code legality check for a command request
  function automatic logic legal_cmd(input logic [7:0] c);
    legal_cmd = (c == fcs_pkg::CMD_READ_ARRAY) || (c == fcs_pkg::CMD_IDENTIFY)
      || (c == fcs_pkg::CMD_READ_STATUS) || (c == fcs_pkg::CMD_CLEAR_STATUS)
      || (c == fcs_pkg::CMD_SUSPEND) || (c == fcs_pkg::CMD_CONFIRM);
  endfunction : legal_cmd
  // request legal unless op is a plain command with a code other than FF, 90, 70, 50, B0 or D0
  function automatic logic ctrl_ok(input logic [31:0] d);
    ctrl_ok = (d[2:0] != fcs_pkg::OP_CMD) || legal_cmd(d[15:8]);
  endfunction : ctrl_ok
  // one flash bus cycle
  fcs_strobe #(.WIDTH(fcs_pkg::STROBE_CYC)) u_strobe (
    .clk_i(CLK_I), .rst_b_i(RST_B_I), .start_i(cyc_start),
    .is_write_i(cyc_write), .dq_in_i(FL_DQ_I), .busy_o(cyc_busy),
    .done_o(cyc_done), .we_n_o(s_we_n), .oe_n_o(s_oe_n), .ce_n_o(s_ce_n),
    .dq_oe_o(s_dq_oe), .rdata_o(cyc_rdata)
  );
  // pin outputs registered
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FL_PINS_O <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rp_n: 1'b0,
                     addr: 18'h00000};
      FL_DQ_O <= 8'h00;
      FL_DQ_OE_O <= 1'b0;
    end else begin
      FL_PINS_O.ce_n <= s_ce_n;
      FL_PINS_O.we_n <= s_we_n;
      FL_PINS_O.oe_n <= s_oe_n;
      FL_PINS_O.rp_n <= (state != ST_RST);
      FL_PINS_O.addr <= addr;
      FL_DQ_O <= cyc_dq;
      FL_DQ_OE_O <= s_dq_oe;
    end
  end
  // AXI write channel capture, either order
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_got <= 1'b0; w_got <= 1'b0;
      aw_addr <= 8'h00; w_data <= 32'h0;
      AWREADY_O <= 1'b0; WREADY_O <= 1'b0;
      BVALID_O <= 1'b0; BRESP_O <= fcs_pkg::RESP_OKAY;
    end else begin
      AWREADY_O <= !aw_got && !AWREADY_O && !BVALID_O;
      WREADY_O <= !w_got && !WREADY_O && !BVALID_O;
      if (AWVALID_I && AWREADY_O) begin
        aw_got <= 1'b1; aw_addr <= AWADDR_I; AWREADY_O <= 1'b0;
      end
      if (WVALID_I && WREADY_O) begin
        w_got <= 1'b1; w_data <= WDATA_I; WREADY_O <= 1'b0;
      end
      if (aw_got && w_got && !BVALID_O) begin
        BVALID_O <= 1'b1;
        BRESP_O <= fcs_pkg::RESP_OKAY;
        if (aw_addr == fcs_pkg::OFS_CTRL && (busy || !ctrl_ok(w_data)))
          BRESP_O <= fcs_pkg::RESP_SLVERR;
        else if (aw_addr != fcs_pkg::OFS_CTRL && aw_addr != fcs_pkg::OFS_ADDR
                 && aw_addr != fcs_pkg::OFS_WDATA)
          BRESP_O <= fcs_pkg::RESP_SLVERR;
      end
      if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0; aw_got <= 1'b0; w_got <= 1'b0;
      end
    end
  end
  logic go;
  assign go = BVALID_O && BREADY_I && BRESP_O == fcs_pkg::RESP_OKAY
              && aw_addr == fcs_pkg::OFS_CTRL;
  // operation sequencer
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= ST_IDLE; op <= fcs_pkg::OP_READ; step <= 2'h0;
      addr <= 18'h00000; wdata <= 8'h00; rdata <= 8'h00; status <= 8'h80;
      busy <= 1'b0; refused <= 1'b0; suspended <= 1'b0;
      array_mode <= 1'b1;
      rst_cnt <= 8'h00; cyc_start <= 1'b0; cyc_write <= 1'b0;
      cyc_dq <= 8'h00;
    end else begin
      cyc_start <= 1'b0;
      if (BVALID_O && BREADY_I && aw_addr == fcs_pkg::OFS_ADDR)
        addr <= w_data[17:0];
      if (BVALID_O && BREADY_I && aw_addr == fcs_pkg::OFS_WDATA)
        wdata <= w_data[7:0];
      case (state)
        ST_IDLE: begin
          if (go) begin
            op <= w_data[2:0]; step <= 2'h0; busy <= 1'b1; refused <= 1'b0;
            if ((w_data[2:0] == fcs_pkg::OP_PROGRAM
                 || w_data[2:0] == fcs_pkg::OP_ERASE)
                && status[fcs_pkg::SUPPLY_ERROR_BIT]) begin
              refused <= 1'b1; busy <= 1'b0;
            end else if (w_data[2:0] == fcs_pkg::OP_RESET) begin
              state <= ST_RST; rst_cnt <= 8'(fcs_pkg::RESET_CYC);
            end else begin
              state <= ST_CYC;
              cyc_start <= 1'b1;
              cyc_write <= (w_data[2:0] != fcs_pkg::OP_READ)
                           && (w_data[2:0] != fcs_pkg::OP_POLL);
              case (w_data[2:0])
                fcs_pkg::OP_CMD: cyc_dq <= w_data[15:8];
                fcs_pkg::OP_PROGRAM: cyc_dq <= fcs_pkg::CMD_WRITE_SETUP;
                fcs_pkg::OP_ERASE: cyc_dq <= fcs_pkg::CMD_ERASE_SETUP;
                default: cyc_dq <= 8'h00;
              endcase
            end
          end
        end
        ST_CYC: begin
          if (cyc_done) begin
            rdata <= cyc_rdata;
            if (op == fcs_pkg::OP_CMD) begin
              array_mode <= (cyc_dq == fcs_pkg::CMD_READ_ARRAY);
              if (cyc_dq == fcs_pkg::CMD_CLEAR_STATUS)
                status[5:3] <= 3'h0;
              if (cyc_dq == fcs_pkg::CMD_SUSPEND) begin
                suspended <= 1'b1;
                state <= ST_POLL; cyc_start <= 1'b1; cyc_write <= 1'b0;
              end else if (cyc_dq == fcs_pkg::CMD_CONFIRM) begin
                suspended <= 1'b0;
                state <= ST_POLL; cyc_start <= 1'b1; cyc_write <= 1'b0;
              end else begin
                state <= ST_DONE;
              end
            end else if ((op == fcs_pkg::OP_PROGRAM || op == fcs_pkg::OP_ERASE)
                         && step == 2'h0) begin
              step <= 2'h1; cyc_start <= 1'b1; cyc_write <= 1'b1;
              // erase sends confirm directly after setup; program sends the data byte
              cyc_dq <= (op == fcs_pkg::OP_ERASE) ? fcs_pkg::CMD_CONFIRM : wdata;
            end else if (op == fcs_pkg::OP_PROGRAM || op == fcs_pkg::OP_ERASE) begin
              array_mode <= 1'b0;
              state <= ST_POLL; cyc_start <= 1'b1; cyc_write <= 1'b0;
            end else if (op == fcs_pkg::OP_POLL) begin
              status <= cyc_rdata; state <= ST_DONE;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_POLL: begin
          // each poll is a fresh oe/ce cycle; no command while busy
          if (cyc_done) begin
            status <= cyc_rdata; rdata <= cyc_rdata;
            if (cyc_rdata[fcs_pkg::READY_BIT]) state <= ST_DONE;
            else cyc_start <= 1'b1;
          end
        end
        ST_RST: begin
          if (rst_cnt == 8'h00) begin
            status <= 8'h80; suspended <= 1'b0;
            array_mode <= 1'b1; state <= ST_DONE;
          end else begin
            rst_cnt <= rst_cnt - 8'h01;
          end
        end
        ST_DONE: begin
          busy <= 1'b0; state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // AXI read channel; status register shows engine flags
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ARREADY_O <= 1'b0; RVALID_O <= 1'b0;
      RDATA_O <= 32'h0; RRESP_O <= fcs_pkg::RESP_OKAY;
    end else begin
      ARREADY_O <= !RVALID_O && !ARREADY_O;
      if (ARVALID_I && ARREADY_O) begin
        ARREADY_O <= 1'b0; RVALID_O <= 1'b1; RRESP_O <= fcs_pkg::RESP_OKAY;
        case (ARADDR_I)
          fcs_pkg::OFS_STATUS:
            RDATA_O <= {20'h0, array_mode, suspended, refused, busy, status};
          fcs_pkg::OFS_RDATA: RDATA_O <= {24'h0, rdata};
          fcs_pkg::OFS_ADDR: RDATA_O <= {14'h0, addr};
          fcs_pkg::OFS_WDATA: RDATA_O <= {24'h0, wdata};
          fcs_pkg::OFS_CTRL: RDATA_O <= {29'h0, op};
          default: begin
            RDATA_O <= 32'h0; RRESP_O <= fcs_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (RVALID_O && RREADY_I) RVALID_O <= 1'b0;
    end
  end
  // program and erase wait for ready after their second cycle
  property prog_polls_p;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (state == ST_CYC && cyc_done && step == 2'h1) |=> state == ST_POLL;
  endproperty
  poll_after_go_a: assert property (prog_polls_p)
    else $error("no status poll after program or erase");
  erase_confirm_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state == ST_CYC && cyc_done && op == fcs_pkg::OP_ERASE && step == 2'h0)
    |=> cyc_dq == fcs_pkg::CMD_CONFIRM)
    else $error("erase setup not followed by confirm");
  supply_block_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (go && state == ST_IDLE && status[fcs_pkg::SUPPLY_ERROR_BIT]
     && w_data[2:0] == fcs_pkg::OP_ERASE) |=> refused && state == ST_IDLE)
    else $error("erase issued with supply error set");
  clear_bits_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state == ST_CYC && cyc_done && op == fcs_pkg::OP_CMD
     && cyc_dq == fcs_pkg::CMD_CLEAR_STATUS) |=> status[5:3] == 3'h0)
    else $error("clear command left error bits");
  busy_no_cmd_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state == ST_POLL) |-> !(cyc_start && cyc_write))
    else $error("write cycle while engine busy");
  cmd_shape_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !s_we_n |-> !s_ce_n && s_oe_n)
    else $error("command cycle with oe low");
  reset_pin_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    $rose(state == ST_RST) |=> ##1 !FL_PINS_O.rp_n)
    else $error("reset pin not pulsed");
  ready_done_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state == ST_POLL && cyc_done && cyc_rdata[fcs_pkg::READY_BIT])
    |=> state == ST_DONE ##1 !busy)
    else $error("ready seen but op not finished");
  legal_code_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state == ST_IDLE && go && w_data[2:0] == fcs_pkg::OP_CMD)
    |-> legal_cmd(w_data[15:8]))
    else $error("undefined command code accepted");
endmodule : fcs_host

/* fcs_flash_model.sv */
// flash device model: command decoder, status register, timed engine
module fcs_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'hC3, // arbitrary value
  parameter int BUSY_TICKS = 150
) (
  input wire fcs_pkg::fcs_pins_s pins_i,
  input wire logic [7:0] dq_i,
  input wire logic supply_ok_i,
  output logic [7:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [2:0] {ARR, IDN, STS, PSET, ESET} fcs_mode_e;
  fcs_mode_e mode = ARR;
  logic [7:0] sr = 8'h80;
  logic [7:0] last = 8'h00;
  logic [7:0] mem [logic [17:0]];
  int left = 0;
  logic erasing = 1'b0;
  logic susp = 1'b0;
  logic no_vpp = 1'b0;
  logic in_wr = 1'b0;

  // reset pin clears status and returns to array reads
  always @(negedge pins_i.rp_n) begin
    sr = 8'h80;
    mode = ARR;
    left = 0;
    in_wr = 1'b0;
    susp = 1'b0;
    erasing = 1'b0;
  end

  // engine countdown, halted while suspended
  always #10 begin
    if (left > 0 && !susp) begin
      left = left - 1;
      if (left == 0) begin
        sr[7] = 1'b1;
        sr[3] = sr[3] | no_vpp;
        if (no_vpp && erasing) sr[5] = 1'b1;
        if (no_vpp && !erasing) sr[4] = 1'b1;
        erasing = 1'b0;
      end
    end
  end

  // start a write or erase unless the supply flag blocks it
  task automatic start(input logic er);
    mode = STS;
    if (!sr[3]) begin
      if (er) mem.delete();
      else if (mem.exists(pins_i.addr)) mem[pins_i.addr] &= dq_i;
      else mem[pins_i.addr] = dq_i;
      sr[7] = 1'b0;
      left = BUSY_TICKS;
      erasing = er;
      no_vpp = !supply_ok_i;
    end
  endtask : start

  // commands and write data latch as the first of ce or we rises
  always @(pins_i.we_n or pins_i.ce_n) begin
    if (!pins_i.ce_n && !pins_i.we_n && pins_i.oe_n && pins_i.rp_n) begin
      in_wr = 1'b1;
    end else if (in_wr) begin
      in_wr = 1'b0;
      if (left > 0 && !susp) begin
        if (erasing && dq_i == fcs_pkg::CMD_SUSPEND) begin
          susp = 1'b1;
          sr[7:6] = 2'b11;
        end
      end else if (mode == PSET) begin
        start(1'b0);
      end else if (mode == ESET) begin
        mode = STS;
        if (dq_i == fcs_pkg::CMD_CONFIRM) start(1'b1);
        else sr[5:4] = 2'b11;
      end else if (susp) begin
        if (dq_i == fcs_pkg::CMD_READ_ARRAY) mode = ARR;
        if (dq_i == fcs_pkg::CMD_READ_STATUS) mode = STS;
        if (dq_i == fcs_pkg::CMD_CONFIRM) begin
          susp = 1'b0;
          sr[7:6] = 2'b00;
          mode = STS;
        end
      end else begin
        case (dq_i)
          fcs_pkg::CMD_READ_ARRAY: mode = ARR;
          fcs_pkg::CMD_IDENTIFY: mode = IDN;
          fcs_pkg::CMD_READ_STATUS: mode = STS;
          fcs_pkg::CMD_CLEAR_STATUS: sr[5:3] = 3'b000;
          fcs_pkg::CMD_ERASE_SETUP: mode = ESET;
          fcs_pkg::CMD_WRITE_SETUP,
          fcs_pkg::CMD_WRITE_SETUP_ALT: mode = PSET;
          default: mode = mode;
        endcase
      end
    end
  end

  // output latched on the later falling strobe; released lines invert
  always @(pins_i.oe_n or pins_i.ce_n) begin
    if (!pins_i.oe_n && !pins_i.ce_n) begin
      if (mode == IDN) last = pins_i.addr[0] ? DEVICE_ID : MAKER_ID;
      else if (mode != ARR) last = sr;
      else if (mem.exists(pins_i.addr)) last = mem[pins_i.addr];
      else last = 8'hFF;
      dq_o = last;
    end else begin
      dq_o = ~last;
    end
  end
endmodule : fcs_flash_model

/* fcs_host_tb_top.sv */
// bench: flash host controller over AXI4-Lite against a flash model
module fcs_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] DEVICE = 8'hC3; // arbitrary value
  logic CLK_I, RST_B_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, FL_DQ_OE_O;
  logic [7:0] AWADDR_I, ARADDR_I, FL_DQ_O, flash_dq, dq_bus;
  logic [31:0] WDATA_I, RDATA_O;
  logic [1:0] BRESP_O, RRESP_O, op_resp;
  fcs_pkg::fcs_pins_s FL_PINS_O;
  logic supply_ok;
  int fails = 0;
  int n_checks = 0;

  // host owns the data lines while its driver is enabled, the flash model otherwise
  assign dq_bus = FL_DQ_OE_O ? FL_DQ_O : flash_dq;

  fcs_host i_fcs_host (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
    .WDATA_I(WDATA_I), .WSTRB_I(4'hF), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
    .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I),
    .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
    .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .FL_PINS_O(FL_PINS_O),
    .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O), .FL_DQ_I(dq_bus));

  fcs_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) i_fcs_flash_model (
    .pins_i(FL_PINS_O), .dq_i(dq_bus), .supply_ok_i(supply_ok),
    .dq_o(flash_dq));

  // clock source
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one AXI write; address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    while (aw || w) begin
      @(posedge CLK_I);
      if (AWREADY_O) aw = 1'b0;
      if (WREADY_O) w = 1'b0;
      AWVALID_I <= aw;
      WVALID_I <= w;
    end
    while (!BVALID_O) @(posedge CLK_I);
    r = BRESP_O;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    do @(posedge CLK_I); while (!ARREADY_O);
    ARVALID_I <= 1'b0;
    do @(posedge CLK_I); while (!RVALID_O);
    d = RDATA_O;
    r = RRESP_O;
  endtask : axr

  // start an operation and poll until the host is idle again
  task automatic op(input logic [2:0] o, input logic [7:0] code);
    logic [31:0] s;
    logic [1:0] r;
    axw(fcs_pkg::OFS_CTRL, {16'h0, code, 5'h0, o}, op_resp);
    s = 32'h100;
    while (s[8]) axr(fcs_pkg::OFS_STATUS, s, r);
  endtask : op

  task automatic rs(output logic [31:0] s);
    logic [1:0] r;
    axr(fcs_pkg::OFS_STATUS, s, r);
  endtask : rs

  task automatic prog(input logic [2:0] o, input logic [17:0] a,
                      input logic [7:0] v);
    logic [1:0] r;
    axw(fcs_pkg::OFS_ADDR, {14'h0, a}, r);
    axw(fcs_pkg::OFS_WDATA, {24'h0, v}, r);
    op(o, 8'h00);
  endtask : prog

  task automatic rd(input logic [17:0] a, output logic [31:0] d);
    logic [1:0] r;
    axw(fcs_pkg::OFS_ADDR, {14'h0, a}, r);
    op(fcs_pkg::OP_READ, 8'h00);
    axr(fcs_pkg::OFS_RDATA, d, r);
  endtask : rd

  // array read after other commands: back to array mode first
  task automatic rda(input logic [17:0] a, output logic [31:0] d);
    op(fcs_pkg::OP_CMD, fcs_pkg::CMD_READ_ARRAY);
    rd(a, d);
  endtask : rda

  // each write strobe ends with the read strobe off
  always @(posedge FL_PINS_O.we_n) begin
    if (RST_B_I === 1'b1) chk("oe in write", 32'(FL_PINS_O.oe_n), 1);
  end

  task automatic t_basic;
    logic [31:0] s;
    rs(s);
    chk("reset status", s & 32'hFFF, 32'h880);
    rd(18'h00007, s);
    chk("erased byte", s & 32'hFF, 32'hFF);
    prog(fcs_pkg::OP_PROGRAM, 18'h00123, 8'h3C);
    rs(s);
    chk("program status", s & 32'h3FF, 32'h080);
    rda(18'h00123, s);
    chk("programmed byte", s & 32'hFF, 32'h3C);
    prog(fcs_pkg::OP_PROGRAM, 18'h00123, 8'h0F);
    rda(18'h00123, s);
    chk("second program", s & 32'hFF, 32'h0C);
    op(fcs_pkg::OP_CMD, fcs_pkg::CMD_IDENTIFY);
    for (int i = 0; i < 3; i++) begin
      rd(18'(i % 2), s);
      chk("id byte", s & 32'hFF, {24'h0, i % 2 ? DEVICE : MAKER});
    end
    $display("test basic done");
  endtask : t_basic

  task automatic t_codes;
    logic [7:0] bad [5] = '{8'h00, 8'h20, 8'h40, 8'h10, 8'hAB};
    logic [7:0] good [5] = '{8'hFF, 8'h70, 8'h50, 8'hB0, 8'hD0};
    logic [31:0] s;
    logic [1:0] r;
    foreach (bad[i]) begin
      axw(fcs_pkg::OFS_CTRL, {16'h0, bad[i], 5'h0, fcs_pkg::OP_CMD}, r);
      chk("bad code", 32'(r), 32'(fcs_pkg::RESP_SLVERR));
    end
    foreach (good[i]) begin
      op(fcs_pkg::OP_CMD, good[i]);
      chk("good code", 32'(op_resp), 32'(fcs_pkg::RESP_OKAY));
    end
    axw(8'h40, 32'h0, r);
    chk("unmapped write", 32'(r), 32'(fcs_pkg::RESP_SLVERR));
    axr(8'h40, s, r);
    chk("unmapped read", {s[29:0], r}, 32'(fcs_pkg::RESP_SLVERR));
    axw(fcs_pkg::OFS_ADDR, 32'h123, r);
    axw(fcs_pkg::OFS_CTRL, 32'(fcs_pkg::OP_ERASE), r);
    axw(fcs_pkg::OFS_CTRL, 32'(fcs_pkg::OP_POLL), r);
    chk("busy ctrl", 32'(r), 32'(fcs_pkg::RESP_SLVERR));
    op(fcs_pkg::OP_POLL, 8'h00);
    rs(s);
    chk("erase status", s & 32'h3FF, 32'h080);
    rda(18'h00123, s);
    chk("erased again", s & 32'hFF, 32'hFF);
    $display("test codes done");
  endtask : t_codes

  task automatic t_supply;
    logic [31:0] s;
    supply_ok <= 1'b0;
    prog(fcs_pkg::OP_PROGRAM, 18'h00040, 8'h55);
    rs(s);
    chk("no supply write", s & 32'h2FF, 32'h098);
    supply_ok <= 1'b1;
    prog(fcs_pkg::OP_PROGRAM, 18'h00041, 8'h66);
    rs(s);
    chk("refused write", s & 32'h2FF, 32'h298);
    prog(fcs_pkg::OP_ERASE, 18'h00041, 8'h00);
    rs(s);
    chk("refused erase", s & 32'h2FF, 32'h298);
    op(fcs_pkg::OP_CMD, fcs_pkg::CMD_CLEAR_STATUS);
    op(fcs_pkg::OP_POLL, 8'h00);
    rs(s);
    chk("cleared", s & 32'hFF, 32'h80);
    supply_ok <= 1'b0;
    prog(fcs_pkg::OP_ERASE, 18'h00040, 8'h00);
    rs(s);
    chk("no supply erase", s & 32'hFF, 32'hA8);
    supply_ok <= 1'b1;
    op(fcs_pkg::OP_RESET, 8'h00);
    rs(s);
    chk("array after pulse", s & 32'h800, 32'h800);
    op(fcs_pkg::OP_CMD, fcs_pkg::CMD_READ_STATUS);
    op(fcs_pkg::OP_POLL, 8'h00);
    rs(s);
    chk("status after pulse", s & 32'hFF, 32'h80);
    $display("test supply done");
  endtask : t_supply

  // watchdog: the run needs a small fraction of this
  initial begin
    #400us;
    fails++;
    summarize();
  end

  // reset, then the scenarios
  initial begin
    RST_B_I = 1'b0;
    AWVALID_I = 1'b0;
    WVALID_I = 1'b0;
    ARVALID_I = 1'b0;
    BREADY_I = 1'b1;
    RREADY_I = 1'b1;
    AWADDR_I = 8'h00;
    ARADDR_I = 8'h00;
    WDATA_I = 32'h0;
    supply_ok = 1'b1;
    repeat (16) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    t_basic();
    t_codes();
    t_supply();
    summarize();
  end
endmodule : fcs_host_tb_top
